/* File: rtl/scis_top.sv */
// Speed command input select: forms speed command, speed limit and set point from two inputs
// Assumes APB master on pclk; analog values arrive already sampled and synchronous to pclk
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "scis_map.svh"

// Function
// - Mode codes 0,4,10,14 accepted, reset 0
// - Mode 0 adds aux to main
// - Negative sum in mode 0 stops motor
// - Mode 10 negative sum reverses direction
// - Direction from start input and sum sign
// - Main input maps to 50-150% override
// - Torque control forms speed limit, no reversal
// - Override speed equals set times percent/100
// - Override scales presets and aux equally
// - Compensation adds aux to preset speed in modes 0 and 10
// - Process control routes main to set point
// - Mode change leaves ramp times untouched
// - Gain register scales full-scale speed
module scis_top
   import scis_pkg::*;
(
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [`SCIS_ADDR_W-1:0] paddr,
   input  wire logic [31:0]             pwdata,
   output logic      [31:0]             prdata,
   output logic                         pready,
   output logic                         pslverr,
   input  wire logic [11:0]             main_input,
   input  wire logic signed [11:0]      aux_input,
   input  wire logic                    forward_start_input,
   input  wire logic                    reverse_start_input,
   input  wire logic                    multispeed_active,
   input  wire logic signed [15:0]      preset_speed,
   output logic signed [15:0]           speed_cmd,
   output logic                         run_fwd,
   output logic                         run_rev,
   output logic [15:0]                  speed_limit,
   output logic [11:0]                  pid_setpoint
);
   scis_state_t        q;
   scis_state_t        d;
   scis_core_if        cif ();
   logic               pid_route;
   logic               ovr_sel;
   logic signed [17:0] aux_s;
   logic signed [17:0] main_s;
   logic signed [15:0] aux_sat;
   logic signed [15:0] add_res;
   logic               access;
   logic               commit;
   logic               mapped;
   logic [31:0]        rd;

   // Analog value times gain over 4096, full-scale main input gives just under the gain as speed
   function automatic logic signed [17:0] scale(input logic signed [12:0] v,
                                                input logic [15:0]        g);
      logic signed [29:0] p;
      p = 30'(v * $signed({1'b0, g}));
      return p[29:`SCIS_GAIN_SHIFT];
   endfunction

   function automatic logic mode_ok(input logic [4:0] m);
      return m == `SCIS_MODE_ADD || m == `SCIS_MODE_OVR ||
             m == `SCIS_MODE_REV || m == `SCIS_MODE_OVR_REV;
   endfunction

   scis_override u_override (
      .c (cif.ovr)
   );

   scis_direction u_direction (
      .c (cif.dir)
   );

   always_comb begin
      d = q;

      // Analog path
      pid_route = q.pcs == `SCIS_PCS_PID_A || q.pcs == `SCIS_PCS_PID_B;
      ovr_sel   = q.mode[`SCIS_MODE_BIT_OVR];
      aux_s     = scale({aux_input[11], aux_input}, q.again);
      main_s    = pid_route ? 18'sh00000 : scale($signed({1'b0, main_input}), q.mgain);
      aux_sat   = scis_sat16(40'(aux_s));
      if (multispeed_active) begin
         add_res = scis_sat16(40'(preset_speed) + (q.comp ? 40'(aux_s) : 40'sh0));
      end else begin
         add_res = scis_sat16(40'(main_s) + 40'(aux_s));
      end

      // Override uses aux, or the preset, as the set speed
      cif.base_speed = multispeed_active ? preset_speed : aux_sat;
      cif.main_raw   = main_input;
      cif.bias       = q.obias;
      cif.gain       = q.ogain;
      cif.neutral    = pid_route;
      cif.fwd        = forward_start_input;
      cif.rev        = reverse_start_input;
      cif.reversible = 1'b0;
      cif.sum        = 16'sh0000;

      d.pid_sp = pid_route ? main_input : 12'h000;

      case (q.cmode)
         SCIS_CM_SPEED: begin
            cif.reversible = q.mode[`SCIS_MODE_BIT_REV];
            cif.sum        = ovr_sel ? cif.ovr_speed : add_res;
            // Negative non-reversible sum falls to stop in the direction helper
            d.speed_cmd    = cif.mag;
            d.run_fwd      = cif.dir_fwd;
            d.run_rev      = cif.dir_rev;
            d.speed_limit  = 16'h0000;
         end
         SCIS_CM_TORQUE: begin
            // Limit is a magnitude; a negative sum never flips it
            cif.sum       = ovr_sel ? cif.ovr_speed : add_res;
            d.speed_limit = cif.sum < 16'sh0000 ? 16'h0000 : cif.sum;
            d.speed_cmd   = 16'sh0000;
            d.run_fwd     = forward_start_input & ~reverse_start_input;
            d.run_rev     = reverse_start_input & ~forward_start_input;
         end
         default: begin
            d.speed_cmd   = 16'sh0000;
            d.speed_limit = 16'h0000;
            d.pid_sp      = 12'h000;
            d.run_fwd     = forward_start_input & ~reverse_start_input;
            d.run_rev     = reverse_start_input & ~forward_start_input;
         end
      endcase

      // APB: one wait state, so read data comes straight from a flop
      access = psel && penable && !q.pready;
      commit = psel && penable && q.pready;
      mapped = 1'b1;
      rd     = 32'h0000_0000;
      if (paddr == `SCIS_OFF_MODE) begin
         rd[4:0] = q.mode;
      end else if (paddr == `SCIS_OFF_CFG) begin
         rd[`SCIS_CFG_CMODE_LSB +: 2] = q.cmode;
         rd[`SCIS_CFG_COMP_BIT]       = q.comp;
         rd[`SCIS_CFG_PCS_LSB +: 8]   = q.pcs;
      end else if (paddr == `SCIS_OFF_GAIN) begin
         rd = {q.again, q.mgain};
      end else if (paddr == `SCIS_OFF_OVR) begin
         rd = {8'h00, q.ogain, 8'h00, q.obias};
      end else if (paddr == `SCIS_OFF_STAT) begin
         rd = {q.run_rev, q.run_fwd, 14'h0000, q.speed_cmd};
      end else if (paddr == `SCIS_OFF_LIMIT) begin
         rd = {4'h0, q.pid_sp, q.speed_limit};
      end else begin
         mapped = 1'b0;
      end

      d.pready  = access;
      d.pslverr = access && !mapped;
      d.prdata  = (access && !pwrite && mapped) ? rd : 32'h0000_0000;

      if (commit && pwrite && mapped) begin
         if (paddr == `SCIS_OFF_MODE) begin
            // Unlisted codes are ignored; ramp settings live elsewhere and stay put
            if (mode_ok(pwdata[4:0])) begin
               d.mode = pwdata[4:0];
            end
         end else if (paddr == `SCIS_OFF_CFG) begin
            d.cmode = scis_cmode_t'(pwdata[`SCIS_CFG_CMODE_LSB +: 2]);
            d.comp  = pwdata[`SCIS_CFG_COMP_BIT];
            d.pcs   = pwdata[`SCIS_CFG_PCS_LSB +: 8];
         end else if (paddr == `SCIS_OFF_GAIN) begin
            d.mgain = pwdata[15:0];
            d.again = pwdata[31:16];
         end else if (paddr == `SCIS_OFF_OVR) begin
            d.obias = pwdata[7:0];
            d.ogain = pwdata[23:16];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q             <= '0;
         q.mode        <= `SCIS_RST_MODE;
         q.cmode       <= SCIS_CM_SPEED;
         q.comp        <= `SCIS_RST_COMP;
         q.pcs         <= `SCIS_RST_PCS;
         q.mgain       <= `SCIS_RST_MGAIN;
         q.again       <= `SCIS_RST_AGAIN;
         q.obias       <= `SCIS_RST_OBIAS;
         q.ogain       <= `SCIS_RST_OGAIN;
      end else begin
         q <= d;
      end
   end

   assign prdata       = q.prdata;
   assign pready       = q.pready;
   assign pslverr      = q.pslverr;
   assign speed_cmd    = q.speed_cmd;
   assign run_fwd      = q.run_fwd;
   assign run_rev      = q.run_rev;
   assign speed_limit  = q.speed_limit;
   assign pid_setpoint = q.pid_sp;
endmodule
`default_nettype wire

/* File: rtl/scis_map.svh */
// Register offsets, field positions, reset values and codes of the speed command input select
// Assumes a 32-bit APB with word-aligned registers and byte addresses in paddr
`ifndef SCIS_MAP_SVH
`define SCIS_MAP_SVH

`define SCIS_ADDR_W        12
`define SCIS_OFF_MODE      12'h000
`define SCIS_OFF_CFG       12'h004
`define SCIS_OFF_GAIN      12'h008
`define SCIS_OFF_OVR       12'h00C
`define SCIS_OFF_STAT      12'h010
`define SCIS_OFF_LIMIT     12'h014

`define SCIS_MODE_ADD      5'h00
`define SCIS_MODE_OVR      5'h04
`define SCIS_MODE_REV      5'h0A
`define SCIS_MODE_OVR_REV  5'h0E
`define SCIS_MODE_BIT_OVR  2
`define SCIS_MODE_BIT_REV  3

`define SCIS_CFG_CMODE_LSB 0
`define SCIS_CFG_COMP_BIT  2
`define SCIS_CFG_PCS_LSB   8

`define SCIS_RST_MODE      5'h00
`define SCIS_RST_CMODE     2'h0
`define SCIS_RST_COMP      1'h0
`define SCIS_RST_PCS       8'h00
`define SCIS_RST_MGAIN     16'h0BB8
`define SCIS_RST_AGAIN     16'h0BB8
`define SCIS_RST_OBIAS     8'h32
`define SCIS_RST_OGAIN     8'h96

`define SCIS_PCS_PID_A     8'h1E
`define SCIS_PCS_PID_B     8'h1F
`define SCIS_FULL_SCALE    17'sh00FFF
`define SCIS_PCT_DIV       34'sh000000064
`define SCIS_PCT_NEUTRAL   17'sh00064
`define SCIS_GAIN_SHIFT    12

`endif

/* File: rtl/scis_pkg.sv */
// Types shared by the speed command input select modules
// Assumes scis_map.svh is on the include path
package scis_pkg;

   typedef enum logic [1:0] {
      SCIS_CM_SPEED,
      SCIS_CM_TORQUE,
      SCIS_CM_POSITION,
      SCIS_CM_POSITION_ALT
   } scis_cmode_t;

   typedef struct packed {
      logic [4:0]         mode;
      scis_cmode_t        cmode;
      logic               comp;
      logic [7:0]         pcs;
      logic [15:0]        mgain;
      logic [15:0]        again;
      logic [7:0]         obias;
      logic [7:0]         ogain;
      logic signed [15:0] speed_cmd;
      logic               run_fwd;
      logic               run_rev;
      logic [15:0]        speed_limit;
      logic [11:0]        pid_sp;
      logic               pready;
      logic               pslverr;
      logic [31:0]        prdata;
   } scis_state_t;

   // Saturate to the signed 16-bit speed range instead of wrapping
   function automatic logic signed [15:0] scis_sat16(input logic signed [39:0] v);
      if (v > 40'sh0000007FFF) begin
         return 16'sh7FFF;
      end else if (v < -40'sh0000008000) begin
         return 16'sh8000;
      end else begin
         return v[15:0];
      end
   endfunction

endpackage

/* File: rtl/scis_core_if.sv */
// Carrier between the top of the speed command input select and its two helpers
// Assumes purely combinational helpers; all state stays in the top
`timescale 1ns/10ps
`default_nettype none
interface scis_core_if;
   logic signed [15:0] base_speed;
   logic [11:0]        main_raw;
   logic [7:0]         bias;
   logic [7:0]         gain;
   logic               neutral;
   logic signed [15:0] ovr_speed;
   logic signed [15:0] sum;
   logic               fwd;
   logic               rev;
   logic               reversible;
   logic               dir_fwd;
   logic               dir_rev;
   logic signed [15:0] mag;

   modport ovr (input base_speed, main_raw, bias, gain, neutral, output ovr_speed);
   modport dir (input sum, fwd, rev, reversible, output dir_fwd, dir_rev, mag);
   modport top (output base_speed, main_raw, bias, gain, neutral, sum, fwd, rev, reversible,
                input ovr_speed, dir_fwd, dir_rev, mag);
endinterface
`default_nettype wire

/* File: rtl/scis_override.sv */
// Override factor from the main input and the scaled speed it gives
// Assumes main_raw spans 0 to full scale as the input spans 0 to 10 V
`timescale 1ns/10ps
`default_nettype none
module scis_override
   import scis_pkg::*;
(
   scis_core_if.ovr c
);
   logic signed [16:0] pct;
   logic signed [33:0] span;
   logic signed [33:0] prod;

   always_comb begin
      // Linear map bias..gain percent across the input range
      span = 34'(($signed({9'h000, c.gain}) - $signed({9'h000, c.bias}))
             * $signed({5'h00, c.main_raw}));
      pct  = 17'($signed({9'h000, c.bias}) + 17'(span / 34'(`SCIS_FULL_SCALE)));
      if (c.neutral) begin
         pct = `SCIS_PCT_NEUTRAL;
      end
      prod = 34'(c.base_speed * pct);
      c.ovr_speed = scis_sat16(40'(prod / `SCIS_PCT_DIV));
   end
endmodule
`default_nettype wire

/* File: rtl/scis_direction.sv */
// Rotation direction from the start inputs and the sign of the command
// Assumes the start inputs are already synchronous levels
`timescale 1ns/10ps
`default_nettype none
module scis_direction
   import scis_pkg::*;
(
   scis_core_if.dir c
);
   logic go;
   logic neg;

   always_comb begin
      // Both starts or none means stop
      go  = c.fwd ^ c.rev;
      neg = c.sum < 16'sh0000;
      c.dir_fwd = 1'b0;
      c.dir_rev = 1'b0;
      c.mag     = 16'sh0000;
      if (go && !neg && c.sum != 16'sh0000) begin
         c.dir_fwd = c.fwd;
         c.dir_rev = c.rev;
         c.mag     = c.sum;
      end else if (go && neg && c.reversible) begin
         c.dir_fwd = c.rev;
         c.dir_rev = c.fwd;
         c.mag     = scis_sat16(-40'(c.sum));
      end
   end
endmodule
`default_nettype wire

/* File: test/scis_assertions.sv */
// Port checker for the speed command input select
// Assumes one pclk domain; bound to the top by the statement at the foot
`timescale 1ns/10ps
`default_nettype none
module scis_chk (
   input wire logic               pclk,
   input wire logic               presetn,
   input wire logic               psel,
   input wire logic               penable,
   input wire logic [11:0]        main_input,
   input wire logic               forward_start_input,
   input wire logic               reverse_start_input,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   input wire logic signed [15:0] speed_cmd,
   input wire logic               run_fwd,
   input wire logic               run_rev,
   input wire logic [15:0]        speed_limit,
   input wire logic [11:0]        pid_setpoint
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence access_s;
      psel && $rose(penable);
   endsequence
   sequence answer_s;
      !pready ##1 pready ##1 !pready;
   endsequence
   apb_wait_a: assert property (access_s |-> answer_s)
      else $error("access not answered after one wait state");
   err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("error answer carries data");
   both_start_a: assert property (forward_start_input && reverse_start_input
      |=> !run_fwd && !run_rev) else $error("both starts did not stop");
   no_start_a: assert property (!forward_start_input && !reverse_start_input
      |=> !run_fwd && !run_rev) else $error("run without start");
   run_excl_a: assert property (!(run_fwd && run_rev))
      else $error("both directions at once");
   cmd_sign_a: assert property (!speed_cmd[15])
      else $error("negative speed command");
   cmd_idle_a: assert property (speed_cmd != 16'sh0000 |-> run_fwd || run_rev)
      else $error("command without direction");
   limit_sign_a: assert property (!speed_limit[15])
      else $error("negative speed limit");
   pid_track_a: assert property (pid_setpoint != 12'h000
      |-> pid_setpoint == $past(main_input)) else $error("set point not main input");
endmodule
bind scis_top scis_chk chk_u (.pclk, .presetn, .psel, .penable, .main_input,
   .forward_start_input, .reverse_start_input, .prdata, .pready, .pslverr, .speed_cmd,
   .run_fwd, .run_rev, .speed_limit, .pid_setpoint);
`default_nettype wire

/* File: test/scis_src.sv */
// Model of the analog speed sources and the start contacts
// Assumes pclk is the block's clock; set changes the inputs right after its next rising edge
`timescale 1ns/10ps
`default_nettype none
module scis_src (
   input  wire logic            pclk,
   output logic [11:0]          main_input,
   output logic signed [11:0]   aux_input,
   output logic                 forward_start_input,
   output logic                 reverse_start_input
);
   initial begin
      main_input = 12'h000;
      aux_input = 12'sh000;
      forward_start_input = 1'b0;
      reverse_start_input = 1'b0;
   end
   // Main input spans 0 to 0xFFF for 0 to 10 V, never negative
   task automatic set(input logic [11:0] m, input logic signed [11:0] a, input logic [1:0] s);
      @(posedge pclk);
      main_input <= m;
      aux_input <= a;
      {forward_start_input, reverse_start_input} <= s;
   endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the speed command input select
// Assumes scis_src drives analog and start inputs; APB is driven here
`timescale 1ns/10ps
`default_nettype none
`include "scis_map.svh"
module tb_top;
   logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
   logic                    forward_start_input, reverse_start_input, multispeed_active;
   logic                    run_fwd, run_rev;
   logic [11:0]             paddr, main_input, pid_setpoint;
   logic signed [11:0]      aux_input;
   logic [31:0]             pwdata, prdata, q;
   logic signed [15:0]      preset_speed, speed_cmd;
   logic [15:0]             speed_limit;
   int                      errors, total_checks;

   scis_src src_u (.pclk, .main_input, .aux_input, .forward_start_input, .reverse_start_input);
   scis_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .main_input, .aux_input, .forward_start_input, .reverse_start_input,
      .multispeed_active, .preset_speed, .speed_cmd, .run_fwd, .run_rev, .speed_limit,
      .pid_setpoint);

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Waits on pready under a bound; the slave latency is not assumed
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         errors++;
         summarize();
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
      apb(1'b0, a, 32'h0);
      chk(q, x);
      chk({31'h0, e}, {31'h0, xe});
   endtask

   // Outputs follow the inputs on the edge that samples them, one edge after set drives them
   task automatic go(input logic [11:0] m, input logic signed [11:0] a, input logic [1:0] s,
                     input logic [15:0] c, input logic [1:0] dir, input logic [15:0] lim);
      src_u.set(m, a, s);
      @(posedge pclk);
      #1;
      chk({16'h0, speed_cmd}, {16'h0, c});
      chk({30'h0, run_fwd, run_rev}, {30'h0, dir});
      chk({16'h0, speed_limit}, {16'h0, lim});
   endtask

   initial begin
      {presetn, psel, penable, pwrite, multispeed_active} = 5'h00;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      preset_speed = 16'sh0000;
      errors = 0;
      total_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // Far side keeps the limit source and aux function selects at 0
      rd(`SCIS_OFF_MODE, 32'h0000_0000, 1'b0);
      rd(`SCIS_OFF_CFG, 32'h0000_0000, 1'b0);
      rd(`SCIS_OFF_GAIN, 32'h0BB8_0BB8, 1'b0);
      rd(`SCIS_OFF_OVR, 32'h0096_0032, 1'b0);
      rd(12'h018, 32'h0000_0000, 1'b1);
      go(12'hFFF, 12'sh000, 2'h2, 16'h0BB7, 2'h2, 16'h0000);
      apb(1'b1, `SCIS_OFF_GAIN, 32'h1000_1000);
      apb(1'b1, `SCIS_OFF_MODE, 32'h0000_0005);
      rd(`SCIS_OFF_MODE, 32'h0000_0000, 1'b0);
      go(12'h3E8, 12'sh0C8, 2'h2, 16'h04B0, 2'h2, 16'h0000);
      go(12'h3E8, -12'sh5DC, 2'h2, 16'h0000, 2'h0, 16'h0000);
      go(12'h3E8, -12'sh5DC, 2'h1, 16'h0000, 2'h0, 16'h0000);
      go(12'h3E8, 12'sh0C8, 2'h3, 16'h0000, 2'h0, 16'h0000);
      apb(1'b1, `SCIS_OFF_MODE, 32'h0000_000A);
      rd(`SCIS_OFF_MODE, 32'h0000_000A, 1'b0);
      go(12'h3E8, -12'sh5DC, 2'h2, 16'h01F4, 2'h1, 16'h0000);
      go(12'h3E8, -12'sh5DC, 2'h1, 16'h01F4, 2'h2, 16'h0000);
      go(12'h3E8, 12'sh0C8, 2'h1, 16'h04B0, 2'h1, 16'h0000);
      apb(1'b1, `SCIS_OFF_MODE, 32'h0000_0004);
      rd(`SCIS_OFF_MODE, 32'h0000_0004, 1'b0);
      rd(`SCIS_OFF_GAIN, 32'h1000_1000, 1'b0);
      go(12'hFFF, 12'sh3E8, 2'h2, 16'h05DC, 2'h2, 16'h0000);
      go(12'h000, 12'sh3E8, 2'h2, 16'h01F4, 2'h2, 16'h0000);
      go(12'h800, 12'sh3E8, 2'h2, 16'h03E8, 2'h2, 16'h0000);
      multispeed_active <= 1'b1;
      preset_speed <= 16'sh07D0;
      go(12'h000, 12'sh12C, 2'h2, 16'h03E8, 2'h2, 16'h0000);
      preset_speed <= 16'sh7FFF;
      go(12'hFFF, 12'sh000, 2'h2, 16'h7FFF, 2'h2, 16'h0000);
      apb(1'b1, `SCIS_OFF_MODE, 32'h0000_000E);
      rd(`SCIS_OFF_MODE, 32'h0000_000E, 1'b0);
      preset_speed <= 16'sh07D0;
      go(12'hFFF, 12'sh12C, 2'h2, 16'h0BB8, 2'h2, 16'h0000);
      apb(1'b1, `SCIS_OFF_MODE, 32'h0000_0000);
      apb(1'b1, `SCIS_OFF_CFG, 32'h0000_0004);
      go(12'h3E8, 12'sh12C, 2'h2, 16'h08FC, 2'h2, 16'h0000);
      preset_speed <= 16'sh7FFF;
      go(12'h3E8, 12'sh12C, 2'h2, 16'h7FFF, 2'h2, 16'h0000);
      apb(1'b1, `SCIS_OFF_CFG, 32'h0000_0000);
      preset_speed <= 16'sh07D0;
      go(12'h3E8, 12'sh12C, 2'h2, 16'h07D0, 2'h2, 16'h0000);
      multispeed_active <= 1'b0;
      apb(1'b1, `SCIS_OFF_CFG, 32'h0000_0001);
      go(12'h3E8, 12'sh0C8, 2'h2, 16'h0000, 2'h2, 16'h04B0);
      apb(1'b1, `SCIS_OFF_MODE, 32'h0000_000A);
      go(12'h3E8, -12'sh5DC, 2'h2, 16'h0000, 2'h2, 16'h0000);
      apb(1'b1, `SCIS_OFF_MODE, 32'h0000_000E);
      go(12'hFFF, 12'sh3E8, 2'h2, 16'h0000, 2'h2, 16'h05DC);
      // Both position codes must silence the analog paths
      for (int i = 2; i < 4; i++) begin
         apb(1'b1, `SCIS_OFF_CFG, 32'(i));
         go(12'hFFF, 12'sh3E8, 2'h2, 16'h0000, 2'h2, 16'h0000);
         chk({20'h0_0000, pid_setpoint}, 32'h0000_0000);
      end
      apb(1'b1, `SCIS_OFF_MODE, 32'h0000_0000);
      for (int i = 0; i < 2; i++) begin
         apb(1'b1, `SCIS_OFF_CFG, {16'h0000, `SCIS_PCS_PID_A + 8'(i), 8'h00});
         go(12'h3E8, 12'sh0C8, 2'h2, 16'h00C8, 2'h2, 16'h0000);
         chk({20'h0_0000, pid_setpoint}, 32'h0000_03E8);
      end
      // Main input is the set point here, so override must stay neutral
      apb(1'b1, `SCIS_OFF_MODE, 32'h0000_0004);
      go(12'h3E8, 12'sh0C8, 2'h2, 16'h00C8, 2'h2, 16'h0000);
      rd(`SCIS_OFF_STAT, 32'h4000_00C8, 1'b0);
      rd(`SCIS_OFF_LIMIT, 32'h03E8_0000, 1'b0);
      // Mid-run reset must bring the settings back
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      rd(`SCIS_OFF_MODE, 32'h0000_0000, 1'b0);
      rd(`SCIS_OFF_GAIN, 32'h0BB8_0BB8, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire
